// [core/lcc_pkg.sv]
`default_nettype none
package lcc_pkg;
	// ----------------------------------------
	// cluster geometry
	// ----------------------------------------
	localparam int CELLS         = 10;
	localparam int ROW_CLOCKS    = 6;
	localparam int MAX_CTRL      = 10;
	localparam int FANOUT_MAX    = 30;
	localparam int GLOBAL_LINES  = 8;
	localparam int PIN_REGS      = 3;
	localparam int RAM_BITS      = 4608;
	localparam int RAM_WIDTH_MAX = 36;
	// ----------------------------------------
	// local routing field positions
	// ----------------------------------------
	localparam int LR_CLK1       = 0;
	localparam int LR_CLK2       = 1;
	localparam int LR_ENA1       = 2;
	localparam int LR_ENA2       = 3;
	localparam int LR_ACLR1      = 4;
	localparam int LR_ACLR2      = 5;
	localparam int LR_SCLR       = 6;
	localparam int LR_ALOAD      = 7;
	localparam int LR_SLOAD      = 8;
	localparam int LR_ADDNSUB    = 9;
	localparam int LR_W          = 10;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic RST_REG     = 1'b0;
endpackage : lcc_pkg
`default_nettype wire

// [core/lcc_cell.sv]
`timescale 1ns/1ps
`default_nettype none
module lcc_cell (
	// clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// cluster controls
	input  wire logic ena,
	input  wire logic aclr,
	input  wire logic aload,
	input  wire logic sclr,
	input  wire logic sload,
	input  wire logic addnsub,
	input  wire logic first_cell,
	// data
	input  wire logic data_a,
	input  wire logic data_b,
	input  wire logic aload_data,
	input  wire logic carry_in,
	input  wire logic chain_reg_in,
	input  wire logic reg_chain_sel,
	// results
	output var  logic lut_out,
	output var  logic carry_out,
	output var  logic reg_out
);
	import lcc_pkg::*;

	logic b_eff;
	logic cin_eff;
	logic d_in;
	logic reg_q;
	logic reg_d;

	// ----------------------------------------
	// dynamic add or subtract
	// ----------------------------------------
	assign b_eff     = data_b ^ ~addnsub;
	assign cin_eff   = first_cell ? ~addnsub : carry_in;
	assign lut_out   = data_a ^ b_eff ^ cin_eff;
	assign carry_out = (data_a & b_eff) | (cin_eff & (data_a ^ b_eff));
	assign d_in      = reg_chain_sel ? chain_reg_in : lut_out;

	// ----------------------------------------
	// register: async controls modelled synchronously
	// ----------------------------------------
	// fabric clears are sampled on clock; true async would need a second clock tree
	assign reg_d = aclr  ? 1'b0 :
	               aload ? aload_data :
	               sclr  ? 1'b0 :
	               sload ? data_a :
	               ena   ? d_in : reg_q;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reg_q <= RST_REG;
		end else begin
			reg_q <= reg_d;
		end
	end
	assign reg_out = reg_q;

	// ----------------------------------------
	// register checks
	// ----------------------------------------
	property p_clr_wins;
		@(posedge clock) disable iff (sys_rst)
		(aclr || (sclr && !aload)) |=> !reg_out;
	endproperty
	a_clr_wins: assert property (p_clr_wins) else $error("clear lost");

	property p_hold_off;
		@(posedge clock) disable iff (sys_rst)
		(!ena && !aclr && !aload && !sclr && !sload) |=> $stable(reg_out);
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("gated clock moved");

	property p_preset;
		@(posedge clock) disable iff (sys_rst)
		(aload && !aclr && aload_data) |=> reg_out;
	endproperty
	a_preset: assert property (p_preset) else $error("preset failed");
endmodule : lcc_cell
`default_nettype wire

// [core/lcc_cluster.sv]
`timescale 1ns/1ps
`default_nettype none
module lcc_cluster #(
	parameter int N_CELLS = lcc_pkg::CELLS
) (
	// clock and reset
	input  wire logic                          clock,
	input  wire logic                          sys_rst,
	// row clocks and local routing
	input  wire logic [lcc_pkg::ROW_CLOCKS-1:0] row_clocks,
	input  wire logic [lcc_pkg::LR_W-1:0]      local_route,
	input  wire logic [9:0]                    row_sel,
	// per cell configuration
	input  wire logic [N_CELLS-1:0]            cell_clk_sel,
	input  wire logic [N_CELLS-1:0]            cell_aclr_sel,
	input  wire logic [N_CELLS-1:0]            reg_chain_sel,
	input  wire logic [N_CELLS-1:0]            lut_chain_sel,
	// data
	input  wire logic [N_CELLS-1:0]            data_a,
	input  wire logic [N_CELLS-1:0]            data_b,
	input  wire logic [N_CELLS-1:0]            aload_data,
	input  wire logic                          chain_reg_in,
	// results
	output var  logic [N_CELLS-1:0]            lut_q,
	output var  logic [N_CELLS-1:0]            reg_q,
	output var  logic                          carry_q,
	output var  logic                          sub_mode_q,
	output var  logic [3:0]                    ctrl_used_q,
	output var  logic                          ctrl_over_q,
	output var  logic                          edge_q
);
	import lcc_pkg::*;

	// ----------------------------------------
	// control signal generation
	// ----------------------------------------
	logic [LR_W-1:0]       row_s1_q;
	logic [LR_W-1:0]       row_s2_q;
	logic [LR_W-1:0]       ctrl;
	logic [N_CELLS-1:0]    carry;
	logic [N_CELLS-1:0]    lut_raw;
	logic [N_CELLS-1:0]    lut_mix;
	logic [N_CELLS-1:0]    reg_raw;
	logic [N_CELLS-1:0]    chain_in;
	logic [3:0]            used_cnt;
	logic [N_CELLS-1:0]    sel_ena;
	logic [N_CELLS-1:0]    sel_aclr;
	logic                  clk1_q;
	logic                  clk1_rise;
	logic                  clk1_fall;

	// row clocks come from another domain, so two stages first
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			row_s1_q <= '0;
			row_s2_q <= '0;
		end else begin
			row_s1_q <= {{(LR_W-ROW_CLOCKS){1'b0}}, row_clocks};
			row_s2_q <= row_s1_q;
		end
	end

	// each control picks a row clock or local routing
	function automatic logic pick(input logic [LR_W-1:0] rows, input logic [LR_W-1:0] loc,
	                              input logic sel, input int idx);
		pick = sel ? rows[idx % ROW_CLOCKS] : loc[idx];
	endfunction : pick

	genvar g;
	generate
		for (g = 0; g < LR_W; g++) begin : g_ctrl
			assign ctrl[g] = pick(row_s2_q, local_route, row_sel[g], g);
		end
	endgenerate

	// count controls in use; limited by construction to ten wires
	function automatic logic [3:0] popc(input logic [LR_W-1:0] v);
		popc = 4'h0;
		for (int i = 0; i < LR_W; i++) popc = popc + {3'b000, v[i]};
	endfunction : popc
	assign used_cnt = popc(ctrl);

	// clock one as data: rising edge to its half, falling edge to clock two
	assign clk1_rise = ctrl[LR_CLK1] & ~clk1_q;
	assign clk1_fall = ~ctrl[LR_CLK1] & clk1_q;

	// ----------------------------------------
	// control generation checks
	// ----------------------------------------
	sequence s_clk1_rise;
		!ctrl[LR_CLK1] ##1 ctrl[LR_CLK1];
	endsequence
	sequence s_clk1_fall;
		ctrl[LR_CLK1] ##1 !ctrl[LR_CLK1];
	endsequence

	// row levels count only after both stages; a bypass would pass metastable values
	property p_sync;
		@(posedge clock) disable iff (sys_rst)
		1'b1 |-> ##2 (row_s2_q == {{(LR_W-ROW_CLOCKS){1'b0}}, $past(row_clocks, 2)});
	endproperty
	a_sync: assert property (p_sync) else $error("row clock path not two stages");

	property p_route_local;
		@(posedge clock) disable iff (sys_rst)
		(row_sel == '0) |-> (ctrl == local_route);
	endproperty
	a_route_local: assert property (p_route_local) else $error("local routing not passed");

	property p_edge_rise;
		@(posedge clock) disable iff (sys_rst)
		s_clk1_rise |=> edge_q;
	endproperty
	a_edge_rise: assert property (p_edge_rise) else $error("rising edge of clock one missed");

	property p_edge_fall;
		@(posedge clock) disable iff (sys_rst)
		s_clk1_fall |=> edge_q;
	endproperty
	a_edge_fall: assert property (p_edge_fall) else $error("falling edge of clock one missed");

	// ----------------------------------------
	// cells
	// ----------------------------------------
	// pairing is fixed: a cell on clock one sees only enable one
	assign sel_ena  = cell_clk_sel & {N_CELLS{ctrl[LR_ENA2] & (ctrl[LR_CLK2] | clk1_fall)}}
	                | ~cell_clk_sel & {N_CELLS{ctrl[LR_ENA1] & (ctrl[LR_CLK1] | clk1_rise)}};
	assign sel_aclr = cell_aclr_sel & {N_CELLS{ctrl[LR_ACLR2]}}
	                | ~cell_aclr_sel & {N_CELLS{ctrl[LR_ACLR1]}};

	assign chain_in = {reg_raw[N_CELLS-2:0], chain_reg_in};

	generate
		for (g = 0; g < N_CELLS; g++) begin : g_cell
			lcc_cell i_lcc_cell (
				.clock         (clock),
				.sys_rst       (sys_rst),
				.ena           (sel_ena[g]),
				.aclr          (sel_aclr[g]),
				.aload         (ctrl[LR_ALOAD]),
				.sclr          (ctrl[LR_SCLR]),
				.sload         (ctrl[LR_SLOAD]),
				.addnsub       (ctrl[LR_ADDNSUB]),
				.first_cell    (g == 0),
				.data_a        (data_a[g]),
				.data_b        (data_b[g]),
				.aload_data    (aload_data[g]),
				.carry_in      (g == 0 ? 1'b0 : carry[(g == 0) ? 0 : g-1]),
				.chain_reg_in  (chain_in[g]),
				.reg_chain_sel (reg_chain_sel[g]),
				.lut_out       (lut_raw[g]),
				.carry_out     (carry[g]),
				.reg_out       (reg_raw[g])
			);
		end
	endgenerate

	// lookup chain: each cell above cell 0 may pass on its neighbour's output combined with its own
	assign lut_mix[0] = lut_raw[0];
	generate
		for (g = 1; g < N_CELLS; g++) begin : g_lchain
			assign lut_mix[g] = lut_chain_sel[g] ? (lut_raw[g] ^ lut_mix[g-1]) : lut_raw[g];
		end
	endgenerate

	// ----------------------------------------
	// cell control checks
	// ----------------------------------------
	sequence s_plain0;
		reg_chain_sel[0] && sel_ena[0] && !sel_aclr[0] && !ctrl[LR_ALOAD] && !ctrl[LR_SCLR] && !ctrl[LR_SLOAD];
	endsequence
	sequence s_plain1;
		reg_chain_sel[1] && sel_ena[1] && !sel_aclr[1] && !ctrl[LR_ALOAD] && !ctrl[LR_SCLR] && !ctrl[LR_SLOAD];
	endsequence

	property p_pair_one;
		@(posedge clock) disable iff (sys_rst)
		(|(sel_ena & ~cell_clk_sel)) |-> (ctrl[LR_ENA1] && ctrl[LR_CLK1]);
	endproperty
	a_pair_one: assert property (p_pair_one) else $error("set one cell moved without enable one");

	property p_pair_two;
		@(posedge clock) disable iff (sys_rst)
		(|(sel_ena & cell_clk_sel)) |-> ctrl[LR_ENA2];
	endproperty
	a_pair_two: assert property (p_pair_two) else $error("set two cell moved without enable two");

	property p_ena_off;
		@(posedge clock) disable iff (sys_rst)
		(!ctrl[LR_ENA1] && !ctrl[LR_ENA2]) |-> (sel_ena == '0);
	endproperty
	a_ena_off: assert property (p_ena_off) else $error("clock not switched off");

	// clock two idle or not, a falling edge of clock one must move only set-two cells
	property p_fall_two;
		@(posedge clock) disable iff (sys_rst)
		s_clk1_fall ##0 (ctrl[LR_ENA2] && !ctrl[LR_ENA1]) |-> (sel_ena == cell_clk_sel);
	endproperty
	a_fall_two: assert property (p_fall_two) else $error("falling edge not on clock two");

	property p_aclr_one;
		@(posedge clock) disable iff (sys_rst)
		(ctrl[LR_ACLR1] && !ctrl[LR_ACLR2]) |-> (sel_aclr == ~cell_aclr_sel);
	endproperty
	a_aclr_one: assert property (p_aclr_one) else $error("clear one routed wrong");

	property p_chain_head;
		@(posedge clock) disable iff (sys_rst)
		s_plain0 |=> (reg_raw[0] == $past(chain_reg_in));
	endproperty
	a_chain_head: assert property (p_chain_head) else $error("chain input not taken");

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	// registered to keep outputs clean; adds one cycle of latency to every result
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			lut_q       <= '0;
			reg_q       <= '0;
			carry_q     <= 1'b0;
			sub_mode_q  <= 1'b0;
			ctrl_used_q <= 4'h0;
			ctrl_over_q <= 1'b0;
			clk1_q      <= 1'b0;
			edge_q      <= 1'b0;
		end else begin
			lut_q       <= lut_mix;
			reg_q       <= reg_raw;
			carry_q     <= carry[N_CELLS-1];
			sub_mode_q  <= ~ctrl[LR_ADDNSUB];
			ctrl_used_q <= used_cnt;
			ctrl_over_q <= (used_cnt > 4'(MAX_CTRL));
			clk1_q      <= ctrl[LR_CLK1];
			edge_q      <= clk1_rise | clk1_fall;
		end
	end

	// ----------------------------------------
	// output checks
	// ----------------------------------------
	property p_limit;
		@(posedge clock) disable iff (sys_rst)
		1'b1 |=> (ctrl_used_q == 4'($countones($past(ctrl)))) && !ctrl_over_q;
	endproperty
	a_limit: assert property (p_limit) else $error("control count wrong");

	property p_sub;
		@(posedge clock) disable iff (sys_rst)
		1'b1 |=> (sub_mode_q == !$past(ctrl[LR_ADDNSUB]));
	endproperty
	a_sub: assert property (p_sub) else $error("mode flag wrong");

	property p_add_sum;
		@(posedge clock) disable iff (sys_rst)
		(ctrl[LR_ADDNSUB] && (lut_chain_sel == '0))
		|=> ({carry_q, lut_q} == ({1'b0, $past(data_a)} + {1'b0, $past(data_b)}));
	endproperty
	a_add_sum: assert property (p_add_sum) else $error("sum wrong");

	property p_sub_sum;
		@(posedge clock) disable iff (sys_rst)
		(!ctrl[LR_ADDNSUB] && (lut_chain_sel == '0))
		|=> ({carry_q, lut_q} == ({1'b0, $past(data_a)} + {1'b0, ~$past(data_b)} + 1'b1));
	endproperty
	a_sub_sum: assert property (p_sub_sum) else $error("difference wrong");

	property p_lchain;
		@(posedge clock) disable iff (sys_rst)
		!lut_chain_sel[1] |=> (lut_q[1] == $past(lut_raw[1]));
	endproperty
	a_lchain: assert property (p_lchain) else $error("lookup chain wrong");

	property p_lchain_on;
		@(posedge clock) disable iff (sys_rst)
		lut_chain_sel[1] |=> (lut_q[1] == $past(lut_raw[1] ^ lut_raw[0]));
	endproperty
	a_lchain_on: assert property (p_lchain_on) else $error("lookup chain not passed on");

	property p_rchain;
		@(posedge clock) disable iff (sys_rst)
		s_plain1 |=> (reg_raw[1] == $past(reg_raw[0]));
	endproperty
	a_rchain: assert property (p_rchain) else $error("register chain wrong");

	property p_reg_out;
		@(posedge clock) disable iff (sys_rst)
		1'b1 |=> (reg_q == $past(reg_raw));
	endproperty
	a_reg_out: assert property (p_reg_out) else $error("register output late");

	property p_edge;
		@(posedge clock) disable iff (sys_rst)
		(clk1_rise || clk1_fall) |=> edge_q;
	endproperty
	a_edge: assert property (p_edge) else $error("edge missed");
endmodule : lcc_cluster
`default_nettype wire

// [dv/lcc_cluster_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module lcc_cluster_tb;
	import lcc_pkg::*;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic                  clock         = 1'b0;
	logic                  sys_rst       = 1'b1;
	logic [ROW_CLOCKS-1:0] row_clocks    = '0;
	logic [LR_W-1:0]       local_route   = '0;
	logic [9:0]            row_sel       = '0;
	logic [CELLS-1:0]      cell_clk_sel  = '0;
	logic [CELLS-1:0]      cell_aclr_sel = '0;
	logic [CELLS-1:0]      reg_chain_sel = '0;
	logic [CELLS-1:0]      lut_chain_sel = '0;
	logic [CELLS-1:0]      data_a        = '0;
	logic [CELLS-1:0]      data_b        = '0;
	logic [CELLS-1:0]      aload_data    = '0;
	logic                  chain_reg_in  = 1'b0;
	logic [CELLS-1:0]      lut_q;
	logic [CELLS-1:0]      reg_q;
	logic                  carry_q;
	logic                  sub_mode_q;
	logic [3:0]            ctrl_used_q;
	logic                  ctrl_over_q;
	logic                  edge_q;
	logic [CELLS:0]        sum;
	int                    n_errors      = 0;
	int                    check_count   = 0;
	int                    t0;
	int                    t9;
	always #12.5 clock = ~clock;
	lcc_cluster #(.N_CELLS(CELLS)) i_lcc_cluster (
		.clock(clock), .sys_rst(sys_rst), .row_clocks(row_clocks), .local_route(local_route),
		.row_sel(row_sel), .cell_clk_sel(cell_clk_sel), .cell_aclr_sel(cell_aclr_sel),
		.reg_chain_sel(reg_chain_sel), .lut_chain_sel(lut_chain_sel), .data_a(data_a),
		.data_b(data_b), .aload_data(aload_data), .chain_reg_in(chain_reg_in), .lut_q(lut_q),
		.reg_q(reg_q), .carry_q(carry_q), .sub_mode_q(sub_mode_q), .ctrl_used_q(ctrl_used_q),
		.ctrl_over_q(ctrl_over_q), .edge_q(edge_q));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// inputs always move 1 ns after the edge, never on it
	task automatic cycles(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cycles
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	// ----------------------------------------
	// watchdog, generous against about 170 cycles of tests
	// ----------------------------------------
	initial begin
		#(2000 * 25);
		n_errors++;
		complete_run();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		cycles(8);
		check({reg_q, lut_q}, '0);
		check({carry_q, sub_mode_q, ctrl_used_q, ctrl_over_q, edge_q}, '0);
		sys_rst = 1'b0;
		$display("test reset done");
		// both modes, plus equal operands as the borrow boundary
		for (int k = 0; k < 4; k++) begin
			local_route[LR_ADDNSUB] = k[0];
			data_a = 10'h2C5;
			data_b = k[1] ? 10'h2C5 : 10'h1F3;
			cycles(4);
			sum = k[0] ? {1'b0, data_a} + {1'b0, data_b} : {1'b0, data_a} + {1'b0, ~data_b} + 11'h001;
			check(lut_q, sum[9:0]);
			check(carry_q, sum[10]);
			check(sub_mode_q, !k[0]);
		end
		$display("test add and subtract done");
		// row clock 3 overrides the local addnsub level
		row_sel[LR_ADDNSUB] = 1'b1;
		cycles(6);
		check(sub_mode_q, 1'b1);
		row_clocks[LR_ADDNSUB % ROW_CLOCKS] = 1'b1;
		cycles(6);
		check(sub_mode_q, 1'b0);
		row_sel = '0;
		local_route = 10'h3FF;
		cycles(4);
		check(ctrl_used_q, 4'hA);
		check(ctrl_over_q, 1'b0);
		local_route = 10'h0A5;
		cycles(4);
		check(ctrl_used_q, 4'h4);
		$display("test control routing done");
		local_route = LR_W'((1 << LR_CLK1) | (1 << LR_ENA1));
		reg_chain_sel = '1;
		chain_reg_in = 1'b1;
		cycles(20);
		check(reg_q, 10'h3FF);
		chain_reg_in = 1'b0;
		t0 = -1;
		t9 = -1;
		for (int i = 0; i < 30; i++) begin
			cycles(1);
			if (t0 < 0 && reg_q[0] === 1'b0) t0 = i;
			if (t9 < 0 && reg_q[9] === 1'b0) t9 = i;
		end
		check(32'(t9 - t0), 32'h0000_0009);
		// enable two must not gate set-one cells
		local_route = LR_W'((1 << LR_CLK1) | (1 << LR_ENA2));
		chain_reg_in = 1'b1;
		cycles(20);
		check(reg_q, '0);
		cell_clk_sel = '1;
		local_route = LR_W'((1 << LR_CLK1) | (1 << LR_CLK2) | (1 << LR_ENA2));
		cycles(20);
		check(reg_q, 10'h3FF);
		// clock two idle: only a falling edge of clock one moves set-two cells
		chain_reg_in = 1'b0;
		local_route = LR_W'((1 << LR_CLK1) | (1 << LR_ENA2));
		cycles(4);
		check(reg_q, 10'h3FF);
		check(edge_q, 1'b0);
		local_route = LR_W'(1 << LR_ENA2);
		cycles(1);
		check(edge_q, 1'b1);
		cycles(1);
		check(edge_q, 1'b0);
		cycles(4);
		check(reg_q, 10'h3FE);
		$display("test chain and enable done");
		cell_clk_sel = '0;
		reg_chain_sel = '0;
		local_route = LR_W'((1 << LR_CLK1) | (1 << LR_ENA1) | (1 << LR_SLOAD));
		cycles(6);
		check(reg_q, 10'h2C5);
		local_route[LR_SCLR] = 1'b1;
		cycles(6);
		check(reg_q, '0);
		local_route[LR_ALOAD] = 1'b1;
		aload_data = 10'h35A;
		cycles(6);
		check(reg_q, 10'h35A);
		cell_aclr_sel = 10'h0F0;
		local_route[LR_ACLR1] = 1'b1;
		cycles(6);
		check(reg_q, 10'h050);
		$display("test register priority done");
		local_route = LR_W'(1 << LR_ADDNSUB);
		data_a = 10'h001;
		data_b = '0;
		lut_chain_sel = 10'h00E;
		cycles(4);
		check(lut_q, 10'h00F);
		check(carry_q, 1'b0);
		$display("test lookup chain done");
		complete_run();
	end
endmodule : lcc_cluster_tb
`default_nettype wire
